// File: hdl/acc_clk_div.sv
// converter clock enable divider
`timescale 1ns/1ps
`default_nettype none
`include "acc_consts.svh"
module acc_clk_div #(
  parameter int DIV_W = `ACC_DIV_W
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // divider setting and enable out
  acc_tick_if.gen t
);
  logic [DIV_W:0] cnt_ff;
  logic [DIV_W:0] last;

  // period is 2*(div+1) clocks
  assign last = {t.div, 1'b1};
  assign t.tick = (cnt_ff >= last);

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      cnt_ff <= '0;
    else if (cnt_ff >= last)
      cnt_ff <= '0;
    else
      cnt_ff <= cnt_ff + 1'b1;
  end
endmodule : acc_clk_div
`default_nettype wire

// File: hdl/acc_ctrl.sv
// conversion sequencer, result store, flags and compare window
//
// Overview of operation
// - converter clock is peripheral clock over 2 (field 0) to 512 (field 255)
// - each channel is tracked for the programmed number of converter cycles
// - reset gives 10-bit; low-res gives 8-bit in low bits, top bits zero
// - completed result goes to channel register and last-result register
// - with tag set, last result also reports its channel number
// - completion sets channel done and ready flags; ready rise requests dma
// - channel result read clears its done flag; last read clears ready
// - new result before previous read sets that channel's overrun flag
// - new result while ready is set sets the general overrun flag
// - overrun read clears channel overruns; status read clears general overrun
// - start pulse acts as a software trigger
// - hardware trigger picked by source field, gated by trigger enable
// - hardware trigger acts on rising edge after synchronisation delay
// - one trigger converts all enabled slots, then idles
// - dma carries only results of enabled slots
// - sleep mode powers cell, waits startup, converts, powers down
// - user sequence follows slot channel numbers, slot gated by its enable
// - compare low, high or both, on one channel or all
// - compare flag rises after programmed consecutive matches
// - thresholds are full scale and adjusted internally in low-res
`timescale 1ns/1ps
`default_nettype none
`include "acc_consts.svh"
module acc_ctrl #(
  parameter int NCH = `ACC_NCH,
  parameter int CH_W = `ACC_CH_W,
  parameter int RES_W = `ACC_RES_W
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // mode settings
  input wire logic [`ACC_DIV_W-1:0] clock_divider_field,
  input wire logic [`ACC_TRK_W-1:0] track_time_field,
  input wire logic [`ACC_SU_W-1:0] startup_field,
  input wire logic low_resolution_bit,
  input wire logic sleep_bit,
  input wire logic tag_bit,
  input wire logic user_sequence_bit,
  input wire logic [NCH*CH_W-1:0] sequence_slot_field,
  // triggers
  input wire logic sw_start,
  input wire logic hw_trigger_enable,
  input wire logic [2:0] trigger_source_field,
  input wire logic [`ACC_NTIMER-1:0] timer_output_a,
  input wire logic external_trigger_pin,
  // channel enable and disable writes
  input wire logic chan_enable_wr,
  input wire logic chan_disable_wr,
  input wire logic [NCH-1:0] chan_wr_mask,
  output logic [NCH-1:0] channel_enable_bit,
  // compare window
  input wire logic [1:0] compare_mode_field,
  input wire logic [CH_W-1:0] compare_channel_field,
  input wire logic compare_all_bit,
  input wire logic [`ACC_FLT_W-1:0] compare_filter_field,
  input wire logic [RES_W-1:0] compare_low,
  input wire logic [RES_W-1:0] compare_high,
  // read strobes that clear flags
  input wire logic rd_channel_result,
  input wire logic [CH_W-1:0] rd_channel_index,
  input wire logic rd_last_result,
  input wire logic rd_overrun,
  input wire logic rd_status,
  // results and flags
  output logic [NCH*RES_W-1:0] channel_result_flat,
  output logic [RES_W-1:0] last_result_field,
  output logic [CH_W-1:0] result_channel_field,
  output logic [NCH-1:0] channel_done_flag,
  output logic result_ready_flag,
  output logic [NCH-1:0] channel_overrun_flag,
  output logic general_overrun_flag,
  output logic compare_event_flag,
  output logic dma_request,
  output logic busy,
  // analog cell
  output logic adc_power,
  output logic [CH_W-1:0] adc_channel,
  output logic adc_start,
  input wire logic adc_done,
  input wire logic [RES_W-1:0] adc_data
);

  ////////////////////////////////////////////////////////////////////////////
  // converter clock and trigger inputs

  acc_tick_if #(.DIV_W(`ACC_DIV_W)) t_if ();

  assign t_if.div = clock_divider_field;

  acc_clk_div #(.DIV_W(`ACC_DIV_W)) u_div (
    .clock(clock),
    .nrst(nrst),
    .t(t_if.gen)
  );

  logic tick;
  assign tick = t_if.tick;

  logic [`ACC_NTIMER:0] trg_pin;
  logic [`ACC_NTIMER:0] trg_rise;
  assign trg_pin = {external_trigger_pin, timer_output_a};

  genvar gi;
  generate
    for (gi = 0; gi <= `ACC_NTIMER; gi++)
    begin : g_sync
      acc_edge_sync u_sync (
        .clock(clock),
        .nrst(nrst),
        .pin_in(trg_pin[gi]),
        .rise(trg_rise[gi])
      );
    end
  endgenerate

  logic hw_sel;
  logic hw_go;
  logic go;

  assign hw_sel = (trigger_source_field < `ACC_TRG_EXT) ? trg_rise[trigger_source_field[1:0]]
                                                        : trg_rise[`ACC_NTIMER];
  assign hw_go = hw_trigger_enable & hw_sel;
  assign go = sw_start | hw_go;

  ////////////////////////////////////////////////////////////////////////////
  // channel enables

  logic [NCH-1:0] chen_ff;

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      chen_ff <= `ACC_CHEN_RST;
    else
      chen_ff <= (chen_ff | (chan_enable_wr ? chan_wr_mask : '0)) & ~(chan_disable_wr ? chan_wr_mask : '0);
  end

  assign channel_enable_bit = chen_ff;

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  acc_pkg::acc_state_t state_ff;
  acc_pkg::acc_state_t nxt_state;
  logic [CH_W-1:0] slot_ff;
  logic [`ACC_TRK_W-1:0] cnt_ff;
  logic [CH_W-1:0] ch_ff;
  logic start_ff;
  logic power_ff;
  logic [CH_W-1:0] slot_ch;
  logic wr_ev;

  // slot gives the channel in user order
  assign slot_ch = user_sequence_bit ? sequence_slot_field[slot_ff*CH_W +: CH_W] : slot_ff;
  assign wr_ev = (state_ff == acc_pkg::ACC_CONV) && adc_done;

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      acc_pkg::ACC_IDLE:
        // power-up wait only in sleep mode
        if (go)
          nxt_state = sleep_bit ? acc_pkg::ACC_WAKE : acc_pkg::ACC_SCAN;
      acc_pkg::ACC_WAKE:
        if (tick && cnt_ff == startup_field)
          nxt_state = acc_pkg::ACC_SCAN;
      acc_pkg::ACC_SCAN:
        // skip disabled slots, idle after the last
        if (chen_ff[slot_ff])
          nxt_state = acc_pkg::ACC_TRACK;
        else if (slot_ff == `ACC_LAST_SLOT)
          nxt_state = acc_pkg::ACC_IDLE;
      acc_pkg::ACC_TRACK:
        if (tick && cnt_ff == track_time_field)
          nxt_state = acc_pkg::ACC_CONV;
      acc_pkg::ACC_CONV:
        if (adc_done)
          nxt_state = (slot_ff == `ACC_LAST_SLOT) ? acc_pkg::ACC_IDLE : acc_pkg::ACC_SCAN;
      default:
        nxt_state = acc_pkg::ACC_IDLE;
    endcase
  end

  // triggers inside a sequence are ignored
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      state_ff <= acc_pkg::ACC_IDLE;
    else
      state_ff <= nxt_state;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      slot_ff <= '0;
    else if (state_ff == acc_pkg::ACC_IDLE)
      slot_ff <= '0;
    else if ((state_ff == acc_pkg::ACC_SCAN && !chen_ff[slot_ff]) || wr_ev)
      slot_ff <= slot_ff + 1'b1;
  end

  // shared counter for startup and tracking, in converter cycles
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      cnt_ff <= '0;
    else if (nxt_state != state_ff)
      cnt_ff <= '0;
    else if (tick && (state_ff == acc_pkg::ACC_WAKE || state_ff == acc_pkg::ACC_TRACK))
      cnt_ff <= cnt_ff + 1'b1;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      ch_ff <= '0;
    else if (state_ff == acc_pkg::ACC_SCAN && chen_ff[slot_ff])
      ch_ff <= slot_ch;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      start_ff <= 1'b0;
    else
      start_ff <= (state_ff == acc_pkg::ACC_TRACK) && (nxt_state == acc_pkg::ACC_CONV);
  end

  // cell is off between sequences in sleep mode
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      power_ff <= 1'b0;
    else
      power_ff <= !sleep_bit || (nxt_state != acc_pkg::ACC_IDLE);
  end

  assign adc_channel = ch_ff;
  assign adc_start = start_ff;
  assign adc_power = power_ff;
  assign busy = (state_ff != acc_pkg::ACC_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // results

  logic [RES_W-1:0] res_new;
  logic [RES_W-1:0] res_ff [NCH];
  logic [RES_W-1:0] last_ff;
  logic [CH_W-1:0] lch_ff;

  // low-res keeps the top 8 bits, moved down
  assign res_new = low_resolution_bit ? {2'h0, adc_data[RES_W-1:2]} : adc_data;

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < NCH; i++)
        res_ff[i] <= '0;
      last_ff <= '0;
      lch_ff <= '0;
    end
    else if (wr_ev)
    begin
      res_ff[ch_ff] <= res_new;
      last_ff <= res_new;
      lch_ff <= ch_ff;
    end
  end

  generate
    for (gi = 0; gi < NCH; gi++)
    begin : g_res
      assign channel_result_flat[gi*RES_W +: RES_W] = res_ff[gi];
    end
  endgenerate

  assign last_result_field = last_ff;
  assign result_channel_field = tag_bit ? lch_ff : '0;

  ////////////////////////////////////////////////////////////////////////////
  // flags; a new event wins over a clearing read in the same cycle

  logic [NCH-1:0] wr_mask;
  logic [NCH-1:0] rd_mask;
  logic [NCH-1:0] done_ff;
  logic [NCH-1:0] ovr_ff;
  logic ready_ff;
  logic general_overrun_flag_ff;
  logic dma_ff;

  assign wr_mask = wr_ev ? NCH'(1) << ch_ff : '0;
  assign rd_mask = rd_channel_result ? NCH'(1) << rd_channel_index : '0;

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      done_ff <= '0;
      ready_ff <= 1'b0;
    end
    else
    begin
      done_ff <= (done_ff & ~rd_mask) | wr_mask;
      ready_ff <= (ready_ff & ~rd_last_result) | wr_ev;
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      ovr_ff <= '0;
      general_overrun_flag_ff <= 1'b0;
    end
    else
    begin
      // cleared by overrun reads only
      ovr_ff <= (rd_overrun ? '0 : ovr_ff) | (wr_mask & done_ff & ~rd_mask);
      // result lands while ready is still set
      general_overrun_flag_ff <= (general_overrun_flag_ff & ~rd_status) | (wr_ev & ready_ff & ~rd_last_result);
    end
  end

  // dma request on each ready rise
  // only enabled slots are ever converted, so only their results are moved
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      dma_ff <= 1'b0;
    else
      dma_ff <= wr_ev & (~ready_ff | rd_last_result);
  end

  assign channel_done_flag = done_ff;
  assign result_ready_flag = ready_ff;
  assign channel_overrun_flag = ovr_ff;
  assign general_overrun_flag = general_overrun_flag_ff;
  assign dma_request = dma_ff;

  ////////////////////////////////////////////////////////////////////////////
  // compare window

  logic [RES_W-1:0] c_lo;
  logic [RES_W-1:0] c_hi;
  logic below;
  logic above;
  logic match;
  logic cmp_on;
  logic hit;
  logic [`ACC_FLT_W-1:0] flt_ff;
  logic cmp_ff;

  // scale thresholds to the stored result width
  assign c_lo = low_resolution_bit ? {2'h0, compare_low[RES_W-1:2]} : compare_low;
  assign c_hi = low_resolution_bit ? {2'h0, compare_high[RES_W-1:2]} : compare_high;
  assign below = res_new < c_lo;
  assign above = res_new > c_hi;

  always_comb
  begin
    case (compare_mode_field)
      `ACC_CMP_LOW: match = below;
      `ACC_CMP_HIGH: match = above;
      `ACC_CMP_IN: match = !below && !above;
      `ACC_CMP_OUT: match = below || above;
      default: match = 1'b0;
    endcase
  end

  assign cmp_on = wr_ev && (compare_all_bit || ch_ff == compare_channel_field);
  assign hit = cmp_on && match && (flt_ff == compare_filter_field);

  // count consecutive matches; a miss restarts the count
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      flt_ff <= '0;
    else if (cmp_on)
      flt_ff <= (!match || hit) ? '0 : flt_ff + 1'b1;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      cmp_ff <= 1'b0;
    else
      cmp_ff <= (cmp_ff & ~rd_status) | hit;
  end

  assign compare_event_flag = cmp_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence s_trig_idle;
    hw_go ##0 (state_ff == acc_pkg::ACC_IDLE);
  endsequence

  sequence s_leave_idle;
    ##1 (state_ff != acc_pkg::ACC_IDLE);
  endsequence

  a_div_fastest: assert property ((t_if.tick && clock_divider_field == '0 ##1 (clock_divider_field == '0) [*2])
    |-> t_if.tick && !$past(t_if.tick))
    else $error("divider zero not half rate");
  a_div_gap: assert property (t_if.tick |=> !t_if.tick)
    else $error("divider ticks back to back");
  a_track_conv: assert property ($rose(state_ff == acc_pkg::ACC_CONV)
    |-> $past(state_ff) == acc_pkg::ACC_TRACK && $past(tick) && $past(cnt_ff) == $past(track_time_field))
    else $error("tracking length wrong");
  a_low_resolution_bit_top: assert property (wr_ev && low_resolution_bit |=> last_ff[RES_W-1 -: 2] == 2'h0)
    else $error("low-res top bits not zero");
  a_store_res: assert property (wr_ev |=> last_ff == res_ff[$past(ch_ff)] && done_ff[$past(ch_ff)])
    else $error("result not stored");
  a_dma_rise: assert property (wr_ev && !ready_ff |=> dma_ff && ready_ff)
    else $error("no dma request on ready rise");
  a_last_clear: assert property (rd_last_result && !wr_ev |=> !ready_ff)
    else $error("ready not cleared by read");
  a_chan_ovr: assert property (wr_ev && done_ff[ch_ff] && !rd_mask[ch_ff] |=> ovr_ff[$past(ch_ff)])
    else $error("channel overrun missed");
  a_gen_ovr: assert property (wr_ev && ready_ff && !rd_last_result |=> general_overrun_flag_ff)
    else $error("general overrun missed");
  a_ovr_clear: assert property (rd_overrun && !wr_ev |=> ovr_ff == '0)
    else $error("overrun not cleared by read");
  a_hw_start: assert property (s_trig_idle |-> s_leave_idle)
    else $error("hardware trigger not taken");
  a_sleep_off: assert property (sleep_bit && state_ff == acc_pkg::ACC_IDLE && $past(state_ff) == acc_pkg::ACC_IDLE
    && $past(sleep_bit) |-> !adc_power)
    else $error("cell powered while asleep");
  a_user_slot: assert property ($rose(state_ff == acc_pkg::ACC_TRACK) && user_sequence_bit && $stable(sequence_slot_field)
    |-> ch_ff == sequence_slot_field[slot_ff*CH_W +: CH_W])
    else $error("user slot channel wrong");

endmodule : acc_ctrl
`default_nettype wire

// File: hdl/acc_edge_sync.sv
// three-stage synchroniser with rising-edge pulse
`timescale 1ns/1ps
`default_nettype none
module acc_edge_sync (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // pin and edge
  input wire logic pin_in,
  output logic rise
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic lvl_ff;

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
    end
    else
    begin
      s1_ff <= pin_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // level only changes when the last two stages agree
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      lvl_ff <= 1'b0;
    else if (s2_ff == s3_ff)
      lvl_ff <= s3_ff;
  end

  assign rise = s2_ff & s3_ff & ~lvl_ff;
endmodule : acc_edge_sync
`default_nettype wire

// File: inc/acc_consts.svh
// counts, widths, reset values and encodings of the conversion controller
`ifndef ACC_CONSTS_SVH
`define ACC_CONSTS_SVH
`define ACC_NCH 8
`define ACC_CH_W 3
`define ACC_RES_W 10
`define ACC_DIV_W 8
`define ACC_TRK_W 4
`define ACC_SU_W 4
`define ACC_FLT_W 2
`define ACC_NTIMER 3
`define ACC_TRG_EXT 3'h3
`define ACC_CHEN_RST 8'h00
`define ACC_CMP_LOW 2'h0
`define ACC_CMP_HIGH 2'h1
`define ACC_CMP_IN 2'h2
`define ACC_CMP_OUT 2'h3
`define ACC_LAST_SLOT 3'h7
`endif

// File: inc/acc_pkg.sv
// shared types of the conversion controller
package acc_pkg;
  typedef enum {ACC_IDLE, ACC_WAKE, ACC_SCAN, ACC_TRACK, ACC_CONV} acc_state_t;
endpackage : acc_pkg

// File: inc/acc_tick_if.sv
// converter clock enable between divider and sequencer
`timescale 1ns/1ps
`default_nettype none
interface acc_tick_if #(parameter int DIV_W = 8);
  logic [DIV_W-1:0] div;
  logic tick;
  modport gen (input div, output tick);
  modport use_side (output div, input tick);
endinterface : acc_tick_if
`default_nettype wire

// File: tb/acc_cell_model.sv
// behavioural analog cell answering conversion starts
`timescale 1ns/1ps
`default_nettype none
module acc_cell_model (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // cell control
  input wire logic adc_power,
  input wire logic [2:0] adc_channel,
  input wire logic adc_start,
  input wire logic [7:0] lat,
  // answer and counts
  output logic adc_done,
  output logic [9:0] adc_data,
  output logic [15:0] starts,
  output logic [15:0] cold
);
  logic [7:0] wait_ff;
  logic [9:0] held_ff;
  ////////////////////////////////////////
  // data toggles while released so a stale value never passes
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      wait_ff <= 8'h00;
      adc_done <= 1'b0;
      adc_data <= 10'h155;
      starts <= 16'h0000;
      cold <= 16'h0000;
    end
    else
    begin
      adc_done <= 1'b0;
      adc_data <= ~adc_data;
      if (adc_start)
      begin
        wait_ff <= lat;
        held_ff <= {adc_channel, 7'h5b};
        starts <= starts + 16'h0001;
        cold <= cold + {15'h0000, !adc_power};
      end
      else if (wait_ff == 8'h01)
      begin
        adc_done <= 1'b1;
        adc_data <= held_ff;
        wait_ff <= 8'h00;
      end
      else if (wait_ff != 8'h00)
        wait_ff <= wait_ff - 8'h01;
    end
  end
endmodule : acc_cell_model
`default_nettype wire

// File: tb/tb.sv
// self-checking bench of the conversion controller
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct {logic [7:0] en; logic lr; logic tg; logic [1:0] md; logic [9:0] lo; logic [9:0] hi; logic ce;} acc_row_t;
  logic clock, nrst, low_resolution_bit, sleep_bit, tag_bit, user_sequence_bit, sw_start, hw_trigger_enable;
  logic external_trigger_pin, chan_enable_wr, chan_disable_wr, compare_all_bit, rd_channel_result;
  logic rd_last_result, rd_overrun, rd_status, adc_done, result_ready_flag, general_overrun_flag;
  logic compare_event_flag, dma_request, busy, adc_power, adc_start;
  logic [7:0] clock_divider_field, chan_wr_mask, channel_enable_bit, channel_done_flag, channel_overrun_flag, lat;
  logic [3:0] track_time_field, startup_field;
  logic [23:0] sequence_slot_field;
  logic [2:0] trigger_source_field, timer_output_a, compare_channel_field, rd_channel_index;
  logic [2:0] result_channel_field, adc_channel;
  logic [1:0] compare_mode_field, compare_filter_field;
  logic [9:0] compare_low, compare_high, last_result_field, adc_data;
  logic [79:0] channel_result_flat;
  logic [15:0] starts, cold, s0;
  int mismatches, compares, dmas, n, hi;
  int dv[3] = '{0, 4, 255};
  int tv[3] = '{5, 2, 0};
  acc_row_t rows[4] = '{'{8'h05, 1'b0, 1'b1, 2'h1, 10'h000, 10'h100, 1'b1},
    '{8'h80, 1'b1, 1'b0, 2'h0, 10'h100, 10'h3ff, 1'b0}, '{8'hff, 1'b0, 1'b1, 2'h2, 10'h0d0, 10'h0e0, 1'b1},
    '{8'h42, 1'b1, 1'b1, 2'h3, 10'h100, 10'h300, 1'b1}};
  acc_ctrl u_dut (.clock, .nrst, .clock_divider_field, .track_time_field, .startup_field, .low_resolution_bit,
    .sleep_bit, .tag_bit, .user_sequence_bit, .sequence_slot_field, .sw_start, .hw_trigger_enable,
    .trigger_source_field, .timer_output_a, .external_trigger_pin, .chan_enable_wr, .chan_disable_wr,
    .chan_wr_mask, .channel_enable_bit, .compare_mode_field, .compare_channel_field, .compare_all_bit,
    .compare_filter_field, .compare_low, .compare_high, .rd_channel_result, .rd_channel_index, .rd_last_result,
    .rd_overrun, .rd_status, .channel_result_flat, .last_result_field, .result_channel_field, .channel_done_flag,
    .result_ready_flag, .channel_overrun_flag, .general_overrun_flag, .compare_event_flag, .dma_request, .busy,
    .adc_power, .adc_channel, .adc_start, .adc_done, .adc_data);
  acc_cell_model u_cell (.clock, .nrst, .adc_power, .adc_channel, .adc_start, .lat, .adc_done, .adc_data,
    .starts, .cold);
  ////////////////////////////////////////
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  always @(posedge clock)
  begin
    if (dma_request === 1'b1)
      dmas++;
  end
  ////////////////////////////////////////
  function automatic logic [9:0] cv(input int c, input logic lr);
    logic [9:0] d;
    d = {c[2:0], 7'h5b};
    return lr ? {2'h0, d[9:2]} : d;
  endfunction : cv
  task automatic chk(input string what, input logic [79:0] exp, input logic [79:0] got);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(posedge clock);
  endtask : cyc
  task automatic start_sw();
    @(posedge clock);
    sw_start <= 1'b1;
    @(posedge clock);
    sw_start <= 1'b0;
  endtask : start_sw
  // bounded wait for the sequencer to go idle
  task automatic wait_idle();
    n = 0;
    @(negedge clock);
    while (busy !== 1'b0 && n < 5000)
    begin
      @(negedge clock);
      n++;
    end
    chk("idle wait", 0, n == 5000);
    repeat (2) @(negedge clock);
  endtask : wait_idle
  task automatic set_en(input logic [7:0] en);
    @(posedge clock);
    chan_disable_wr <= 1'b1;
    chan_wr_mask <= ~en;
    @(posedge clock);
    chan_disable_wr <= 1'b0;
    chan_enable_wr <= 1'b1;
    chan_wr_mask <= en;
    @(posedge clock);
    chan_enable_wr <= 1'b0;
    @(negedge clock);
  endtask : set_en
  // read every result plus last, overrun and status once
  task automatic clear();
    for (int c = 0; c < 8; c++)
    begin
      @(posedge clock);
      rd_channel_result <= 1'b1;
      rd_channel_index <= c[2:0];
      {rd_last_result, rd_overrun, rd_status} <= {3{c == 0}};
    end
    @(posedge clock);
    {rd_channel_result, rd_last_result, rd_overrun, rd_status} <= 4'h0;
    @(negedge clock);
    dmas = 0;
  endtask : clear
  // pin index 0..2 timers, 3 external
  // triggers spaced past sequence
  task automatic hw(input logic [2:0] sel, input int pin, input logic en, input logic exp);
    @(posedge clock);
    hw_trigger_enable <= en;
    trigger_source_field <= sel;
    cyc(2);
    {external_trigger_pin, timer_output_a} <= 4'h1 << pin;
    n = 0;
    @(negedge clock);
    while (busy !== 1'b1 && n < 12)
    begin
      @(negedge clock);
      n++;
    end
    chk("hw start", exp, n >= 2 && n < 12);
    if (exp)
      wait_idle();
    @(posedge clock);
    {external_trigger_pin, timer_output_a} <= 4'h0;
    hw_trigger_enable <= 1'b0;
    clear();
  endtask : hw
  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out
  ////////////////////////////////////////
  initial
  begin
    #2000000;
    mismatches++;
    $display("ERROR watchdog expected finish seen hang");
    close_out();
  end
  initial
  begin
    {nrst, low_resolution_bit, sleep_bit, tag_bit, user_sequence_bit, sw_start, hw_trigger_enable} = 7'h00;
    {external_trigger_pin, chan_enable_wr, chan_disable_wr, rd_channel_result, rd_last_result} = 5'h00;
    {rd_overrun, rd_status, timer_output_a, trigger_source_field, rd_channel_index} = 11'h000;
    {clock_divider_field, track_time_field, startup_field, chan_wr_mask} = 24'h000000;
    {compare_mode_field, compare_channel_field, compare_filter_field, compare_low, compare_high} = 27'h0;
    sequence_slot_field = 24'h000000;
    compare_all_bit = 1'b1;
    lat = 8'h01;
    cyc(5);
    @(negedge clock);
    chk("reset", 0, {busy, channel_enable_bit, result_ready_flag, dma_request, adc_start, channel_done_flag});
    @(posedge clock);
    nrst <= 1'b1;
    cyc(4);
    chk("power up", 1, adc_power);
    foreach (rows[r])
    begin
      s0 = starts;
      lat = 8'(1 + 4 * r);
      @(posedge clock);
      {low_resolution_bit, tag_bit, compare_mode_field} <= {rows[r].lr, rows[r].tg, rows[r].md};
      {compare_low, compare_high} <= {rows[r].lo, rows[r].hi};
      set_en(rows[r].en);
      chk("enables", rows[r].en, channel_enable_bit);
      start_sw();
      wait_idle();
      for (int c = 0; c < 8; c++)
      begin
        if (rows[r].en[c])
        begin
          hi = c;
          chk("result", cv(c, rows[r].lr), channel_result_flat[c*10 +: 10]);
        end
      end
      chk("last", cv(hi, rows[r].lr), last_result_field);
      chk("tag", rows[r].tg ? hi : 0, result_channel_field);
      chk("done", rows[r].en, channel_done_flag);
      chk("ready", 1, result_ready_flag);
      chk("dma", 1, dmas);
      chk("general_overrun_flag", $countones(rows[r].en) > 1, general_overrun_flag);
      chk("convs", $countones(rows[r].en), starts - s0);
      chk("compare", rows[r].ce, compare_event_flag);
      clear();
      chk("cleared", 0, {channel_done_flag, result_ready_flag, channel_overrun_flag, general_overrun_flag});
    end
    lat = 8'h02;
    set_en(8'h01);
    for (int d = 0; d < 3; d++)
    begin
      @(posedge clock);
      {low_resolution_bit, tag_bit} <= 2'h0;
      clock_divider_field <= 8'(dv[d]);
      track_time_field <= 4'(tv[d]);
      start_sw();
      n = 0;
      while (adc_start !== 1'b1 && n < 3000)
      begin
        @(negedge clock);
        n++;
      end
      // first converter cycle of tracking may be partial: phase of the divider is free
      chk("track", 1, n >= tv[d] * 2 * (dv[d] + 1) + 3 && n <= (tv[d] + 1) * 2 * (dv[d] + 1) + 2);
      wait_idle();
      clear();
    end
    @(posedge clock);
    {clock_divider_field, track_time_field} <= 12'h000;
    hw(3'h0, 0, 1'b1, 1'b1);
    hw(3'h1, 1, 1'b1, 1'b1);
    hw(3'h2, 2, 1'b1, 1'b1);
    hw(3'h3, 3, 1'b1, 1'b1);
    hw(3'h6, 3, 1'b1, 1'b1);
    hw(3'h1, 0, 1'b1, 1'b0);
    hw(3'h3, 3, 1'b0, 1'b0);
    @(posedge clock);
    sleep_bit <= 1'b1;
    startup_field <= 4'h3;
    set_en(8'h03);
    chk("asleep", 0, adc_power);
    s0 = starts;
    start_sw();
    cyc(3);
    start_sw();
    @(negedge clock);
    chk("awake", 1, adc_power);
    wait_idle();
    chk("slept", 0, adc_power);
    cyc(40);
    chk("sleep convs", 2, starts - s0);
    chk("cold start", 0, cold);
    clear();
    @(posedge clock);
    sleep_bit <= 1'b0;
    user_sequence_bit <= 1'b1;
    sequence_slot_field <= {15'h7fff, 3'h2, 3'h5, 3'h5};
    set_en(8'h07);
    s0 = starts;
    start_sw();
    wait_idle();
    chk("seq convs", 3, starts - s0);
    chk("seq done", 8'h24, channel_done_flag);
    chk("seq last", cv(2, 1'b0), last_result_field);
    chk("overrun", 8'h20, channel_overrun_flag);
    @(posedge clock);
    {rd_channel_result, rd_channel_index, rd_overrun} <= {1'b1, 3'h5, 1'b1};
    @(posedge clock);
    {rd_channel_result, rd_overrun} <= 2'h0;
    @(negedge clock);
    chk("overrun read", 0, channel_overrun_flag);
    chk("done read", 8'h04, channel_done_flag);
    chk("general_overrun_flag kept", 1, general_overrun_flag);
    clear();
    @(posedge clock);
    user_sequence_bit <= 1'b0;
    {compare_all_bit, compare_filter_field, compare_mode_field} <= 5'h05;
    compare_channel_field <= 3'h2;
    compare_high <= 10'h100;
    set_en(8'h0c);
    for (int k = 0; k < 2; k++)
    begin
      start_sw();
      wait_idle();
      chk("filter", k, compare_event_flag);
    end
    close_out();
  end
endmodule : tb
`default_nettype wire
